// File: design/cfu_compare_flag_unit.sv
// How it works
// - Word-imm compare: memory word minus signed immediate, flags only, memory untouched.
// - Word-imm compare takes a second instruction word holding the 16-bit constant.
// - 16-bit compares: N is sign of the 17-bit exact difference.
// - Z set when difference is zero, cleared otherwise.
// - C cleared on borrow, set otherwise; wide compare leaves C unchanged.
// - Compare after repeat-next: clear repeat count, execute once.
// - Wide compare: 64-bit acc:product against zero, only with object mode set.
// - Wide compare N: acc bit 31 inverted when overflow set.
// - Wide compare Z: set only when all 64 bits zero.
// - Wide compare always clears overflow after using it.
// - Byte compare: selected half minus zero-extended byte.
// - Long compare: accumulator minus 32-bit memory operand, flags only.
// - 32-bit compares: N is sign of the 33-bit exact difference.
// - Shifted-product compare: acc minus shifted product, sets N, Z, C.
// - Shift select 0 is left 1 with zero fill; 1 is no shift; 2..7 is arithmetic right 1..6.
`default_nettype none
module cfu_compare_flag_unit (
  input  wire logic        i_ref_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_instr_valid,
  input  wire logic [15:0] i_instr_word,
  input  wire logic        i_prev_repeat_next_instr,
  input  wire logic        i_object_code_mode_bit,
  input  wire logic [15:0] i_mem_operand_16,
  input  wire logic [31:0] i_mem_operand_32,
  input  wire logic [15:0] i_upper_word_reg,
  input  wire logic [15:0] i_lower_word_reg,
  input  wire logic [31:0] i_product,
  input  wire logic [2:0]  i_product_shift_select,
  input  wire logic        i_overflow_in,
  output logic             o_flags_we,
  output logic             o_overflow_we,
  output logic             o_neg_flag,
  output logic             o_zero_flag,
  output logic             o_carry_flag,
  output logic             o_overflow_flag,
  output logic             o_repeat_count_clr,
  output logic             o_busy
);
  wire logic [31:0] acc = {i_upper_word_reg, i_lower_word_reg};

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  cfu_pkg::cfu_state_t state_q, state_d;
  logic [15:0] mem16_q;

  wire logic idle      = (state_q == cfu_pkg::CFU_IDLE);
  wire logic dv        = i_instr_valid;
  wire logic is_word   = idle && dv && i_instr_word[15:8] == cfu_pkg::OPC_CMP_WORD_IMM;
  wire logic is_wide   = idle && dv && i_instr_word == cfu_pkg::OPC_CMP_WIDE_ZERO
                         && i_object_code_mode_bit;
  wire logic is_byte   = idle && dv && i_instr_word[15:9] == cfu_pkg::OPC_CMP_BYTE_IMM;
  wire logic is_long   = idle && dv && i_instr_word[15:8] == cfu_pkg::OPC_CMP_LONG;
  wire logic is_shp    = idle && dv && i_instr_word == cfu_pkg::OPC_CMP_SHIFT_P;
  wire logic imm_taken = (state_q == cfu_pkg::CFU_WAIT_IMM) && dv;

  // ----------------------------------------
  // Arithmetic
  // ----------------------------------------
  logic [31:0] shifted_p;
  cfu_shifter u_shift (
    .i_product              (i_product),
    .i_product_shift_select (i_product_shift_select),
    .o_shifted              (shifted_p)
  );

  wire logic        half_acc_select = i_instr_word[cfu_pkg::HALF_SEL_BIT];
  wire logic [15:0] half_val  = half_acc_select ? i_upper_word_reg : i_lower_word_reg;
  // 16-bit signed compare with exact sign (word imm)
  wire logic [16:0] dw_s = {mem16_q[15], mem16_q} - {i_instr_word[15], i_instr_word};
  wire logic [16:0] dw_u = {1'b0, mem16_q} - {1'b0, i_instr_word};
  // Byte compare, zero-extended immediate
  wire logic [16:0] db_s = {half_val[15], half_val} - {9'h000, i_instr_word[7:0]};
  wire logic [16:0] db_u = {1'b0, half_val} - {9'h000, i_instr_word[7:0]};
  // 32-bit compares
  wire logic [31:0] sub32 = is_shp ? shifted_p : i_mem_operand_32;
  wire logic [32:0] dl_s = {acc[31], acc} - {sub32[31], sub32};
  wire logic [32:0] dl_u = {1'b0, acc} - {1'b0, sub32};

  wire logic wide_n = i_overflow_in ? ~acc[cfu_pkg::ACC_SIGN_BIT] : acc[cfu_pkg::ACC_SIGN_BIT];
  wire logic wide_z = (acc == 32'h0000_0000) && (i_product == 32'h0000_0000);

  logic n_d, z_d, c_d, we_d;
  always_comb begin
    n_d  = o_neg_flag;
    z_d  = o_zero_flag;
    c_d  = o_carry_flag;
    we_d = 1'b1;
    if (imm_taken) begin
      n_d = dw_s[16];
      z_d = (dw_s[15:0] == 16'h0000);
      c_d = ~dw_u[16];
    end else if (is_byte) begin
      n_d = db_s[16];
      z_d = (db_s[15:0] == 16'h0000);
      c_d = ~db_u[16];
    end else if (is_long || is_shp) begin
      n_d = dl_s[32];
      z_d = (dl_s[31:0] == 32'h0000_0000);
      c_d = ~dl_u[32];
    end else if (is_wide) begin
      n_d = wide_n;
      z_d = wide_z;
    end else begin
      we_d = 1'b0;
    end
  end

  always_comb begin
    state_d = state_q;
    case (state_q)
      cfu_pkg::CFU_IDLE:     if (is_word) state_d = cfu_pkg::CFU_WAIT_IMM;
      cfu_pkg::CFU_WAIT_IMM: if (dv) state_d = cfu_pkg::CFU_IDLE;
      default:               state_d = cfu_pkg::CFU_IDLE;
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      state_q            <= cfu_pkg::CFU_IDLE;
      mem16_q            <= 16'h0000;
      {o_neg_flag, o_zero_flag, o_carry_flag} <= cfu_pkg::FLAGS_RST;
      o_overflow_flag    <= 1'b0;
      o_flags_we         <= 1'b0;
      o_overflow_we      <= 1'b0;
      o_repeat_count_clr <= 1'b0;
    end else begin
      state_q            <= state_d;
      if (is_word) mem16_q <= i_mem_operand_16;
      {o_neg_flag, o_zero_flag, o_carry_flag} <= {n_d, z_d, c_d};
      o_flags_we         <= we_d;
      o_overflow_we      <= is_wide;
      if (is_wide) o_overflow_flag <= 1'b0;
      o_repeat_count_clr <= i_prev_repeat_next_instr
                            && (is_word || is_wide || is_byte || is_long || is_shp);
    end
  end

  assign o_busy = (state_q == cfu_pkg::CFU_WAIT_IMM);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence s_word_issue;
    is_word ##1 imm_taken;
  endsequence

  a_word_two_words: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_word |=> o_busy) else $error("word compare did not wait for immediate");
  a_word_flag_we: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_word_issue |=> o_flags_we) else $error("word compare flags not written");
  a_zero_long: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_long && acc == i_mem_operand_32 |=> o_zero_flag && o_carry_flag)
    else $error("equal long compare wrong Z or C");
  a_borrow_long: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_long && acc < i_mem_operand_32 |=> !o_carry_flag) else $error("borrow did not clear C");
  a_sign_long: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_long && $signed(acc) < $signed(i_mem_operand_32) |=> o_neg_flag)
    else $error("long compare sign wrong");
  a_wide_ovf: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_wide |=> o_overflow_we && !o_overflow_flag) else $error("wide compare kept overflow");
  a_wide_neg: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_wide |=> o_neg_flag == ($past(acc[cfu_pkg::ACC_SIGN_BIT]) ^ $past(i_overflow_in)))
    else $error("wide compare N wrong");
  a_wide_mode: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    idle && dv && i_instr_word == cfu_pkg::OPC_CMP_WIDE_ZERO && !i_object_code_mode_bit
    |=> !o_overflow_we) else $error("wide compare ran outside object mode");
  a_byte_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_byte && half_val == {8'h00, i_instr_word[7:0]} |=> o_zero_flag)
    else $error("byte compare zero missed");
  a_rpt_clear: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_long && i_prev_repeat_next_instr |=> o_repeat_count_clr) else $error("repeat count not cleared");
  a_no_ovf_we: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    (is_long || is_byte || is_shp) |=> !o_overflow_we) else $error("overflow touched");

  // ----------------------------------------
  // Word compare and repeat checks
  // ----------------------------------------
  sequence s_word_done;
    s_word_issue ##1 o_flags_we;
  endsequence

  a_word_release: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_word_done |-> !o_busy)
    else $error("word compare still busy after immediate");
  a_word_sign: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_word_issue |=> o_neg_flag == ($signed($past(i_mem_operand_16, 2)) < $signed($past(i_instr_word))))
    else $error("word compare N wrong");
  a_word_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_word_issue |=> o_zero_flag == ($past(i_mem_operand_16, 2) == $past(i_instr_word)))
    else $error("word compare Z wrong");
  a_word_carry: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_word_issue |=> o_carry_flag == ($past(i_mem_operand_16, 2) >= $past(i_instr_word)))
    else $error("word compare C wrong");
  a_word_no_ovf: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    s_word_issue |=> !o_overflow_we)
    else $error("word compare touched overflow");
  a_rpt_idle: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    !i_prev_repeat_next_instr |=> !o_repeat_count_clr)
    else $error("repeat count cleared without repeat");

  // ----------------------------------------
  // Wide, product, byte and long checks
  // ----------------------------------------
  a_wide_zero: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_wide |=> o_zero_flag == ($past(acc) == 32'h0000_0000 && $past(i_product) == 32'h0000_0000))
    else $error("wide compare Z wrong");
  a_shp_once: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_shp |=> o_flags_we && !o_busy)
    else $error("shifted product compare not single cycle");
  a_shp_plain: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_shp && i_product_shift_select == 3'h1 && acc == i_product |=> o_zero_flag && o_carry_flag)
    else $error("unshifted product compare wrong Z or C");
  a_shp_left: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_shp && i_product_shift_select == 3'h0 && acc == (i_product << 1) |=> o_zero_flag)
    else $error("left shifted product compare Z missed");
  a_shp_right: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_shp && i_product_shift_select == 3'h2 && acc == {i_product[31], i_product[31:1]} |=> o_zero_flag)
    else $error("right shifted product compare Z missed");
  a_byte_borrow: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_byte && half_val < {8'h00, i_instr_word[7:0]} |=> !o_carry_flag)
    else $error("byte compare borrow did not clear C");
  a_long_once: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    is_long |=> o_flags_we && !o_busy)
    else $error("long compare flags not written");
endmodule : cfu_compare_flag_unit
`default_nettype wire

// File: design/cfu_pkg.sv
`default_nettype none
package cfu_pkg;
  // Opcode match patterns (upper byte; byte imm upper 7 bits; wide zero and shift product whole word)
  localparam logic [7:0]  OPC_CMP_WORD_IMM  = 8'h1B;
  localparam logic [15:0] OPC_CMP_WIDE_ZERO = 16'h565E;
  localparam logic [6:0]  OPC_CMP_BYTE_IMM  = 7'h29;
  localparam logic [7:0]  OPC_CMP_LONG      = 8'h0F;
  localparam logic [15:0] OPC_CMP_SHIFT_P   = 16'hFF59;
  // Field positions
  localparam int HALF_SEL_BIT   = 8;
  localparam int ACC_SIGN_BIT   = 31;
  // Reset values
  localparam logic [2:0] FLAGS_RST = 3'h0;

  typedef enum {
    CFU_IDLE,
    CFU_WAIT_IMM
  } cfu_state_t;
endpackage : cfu_pkg
`default_nettype wire

// File: design/cfu_shifter.sv
`default_nettype none
module cfu_shifter (
  input  wire logic [31:0] i_product,
  input  wire logic [2:0]  i_product_shift_select,
  output logic      [31:0] o_shifted
);
  // Select 0: left 1, 1: none, 2..7: arithmetic right 1..6
  wire logic signed [31:0] prod_s = i_product;
  wire logic [2:0] rshift = i_product_shift_select - 3'h1;

  assign o_shifted = (i_product_shift_select == 3'h0) ? {i_product[30:0], 1'b0} :
                     32'(prod_s >>> rshift);
endmodule : cfu_shifter
`default_nettype wire

// File: verification/cfu_compare_flag_unit_tb.sv
`default_nettype none
module cfu_compare_flag_unit_tb;
  timeunit 1ns;
  timeprecision 100ps;
  // --------------------
  // Signals
  // --------------------
  logic        i_ref_clk = 1'b0, i_rst_n = 1'b0, i_instr_valid = 1'b0, i_overflow_in = 1'b0;
  logic        i_prev_repeat_next_instr = 1'b0, i_object_code_mode_bit = 1'b0;
  logic [15:0] i_instr_word = 16'h0000, i_mem_operand_16 = 16'h0000;
  logic [15:0] i_upper_word_reg = 16'h0000, i_lower_word_reg = 16'h0000;
  logic [31:0] i_mem_operand_32 = 32'h00000000, i_product = 32'h00000000;
  logic [2:0]  i_product_shift_select = 3'h1;
  logic        o_flags_we, o_overflow_we, o_neg_flag, o_zero_flag;
  logic        o_carry_flag, o_overflow_flag, o_repeat_count_clr, o_busy;
  int          n_mismatch = 0, cmp_count = 0;
  cfu_compare_flag_unit DUT (.i_ref_clk, .i_rst_n, .i_instr_valid, .i_instr_word, .i_prev_repeat_next_instr,
    .i_object_code_mode_bit, .i_mem_operand_16, .i_mem_operand_32, .i_upper_word_reg, .i_lower_word_reg,
    .i_product, .i_product_shift_select, .i_overflow_in, .o_flags_we, .o_overflow_we, .o_neg_flag,
    .o_zero_flag, .o_carry_flag, .o_overflow_flag, .o_repeat_count_clr, .o_busy);
  always #10 i_ref_clk = ~i_ref_clk;
  // --------------------
  // Tasks
  // --------------------
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic op(input logic [15:0] w);
    @(posedge i_ref_clk);
    #1 i_instr_valid = 1'b1;
    i_instr_word = w;
    @(posedge i_ref_clk);
    #1 i_instr_valid = 1'b0;
  endtask : op
  task automatic flg(input logic [2:0] nzc);
    chk("flags_we", o_flags_we, 1'b1);
    chk("neg", o_neg_flag, nzc[2]);
    chk("zero", o_zero_flag, nzc[1]);
    chk("carry", o_carry_flag, nzc[0]);
    chk("ovf_we", o_overflow_we, 1'b0);
  endtask : flg
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test
  // --------------------
  // Tests
  // --------------------
  initial begin
    #20000;
    n_mismatch++;
    end_of_test();
  end
  initial begin
    repeat (4) @(posedge i_ref_clk);
    #1 i_rst_n = 1'b1;
    chk("we_rst", o_flags_we, 1'b0);
    i_object_code_mode_bit = 1'b1;
    i_upper_word_reg = 16'h8000; i_mem_operand_32 = 32'h00000001;
    op(16'h0F00); flg(3'b101);
    i_mem_operand_32 = 32'h80000000; op(16'h0F21); flg(3'b011);
    i_mem_operand_32 = 32'h80000001; op(16'h0F21); flg(3'b100);
    i_mem_operand_16 = 16'h8000; op(16'h1B05); chk("busy", o_busy, 1'b1);
    chk("early_we", o_flags_we, 1'b0);
    i_mem_operand_16 = 16'h0000; op(16'h0001); flg(3'b101);
    op(16'h1B05); op(16'hFFFF); flg(3'b000);
    {i_upper_word_reg, i_lower_word_reg} = 32'h7FFFFFFF; i_overflow_in = 1'b1;
    op(16'h565E); chk("w_n", o_neg_flag, 1'b1); chk("w_vwe", o_overflow_we, 1'b1);
    chk("w_v", o_overflow_flag, 1'b0); chk("w_z", o_zero_flag, 1'b0);
    {i_upper_word_reg, i_lower_word_reg} = 32'h00000000; i_product = 32'h00000001;
    op(16'h565E); chk("w_z1", o_zero_flag, 1'b0); chk("w_n1", o_neg_flag, 1'b1);
    i_overflow_in = 1'b0; i_product = 32'h00000000;
    op(16'h565E); chk("w_z2", o_zero_flag, 1'b1); chk("w_n2", o_neg_flag, 1'b0);
    i_object_code_mode_bit = 1'b0;
    op(16'h565E); chk("w_obj", o_flags_we, 1'b0); chk("w_objv", o_overflow_we, 1'b0);
    i_object_code_mode_bit = 1'b1; i_upper_word_reg = 16'h0080; op(16'h5380); flg(3'b011);
    i_lower_word_reg = 16'h0005; op(16'h5210); flg(3'b100);
    {i_upper_word_reg, i_lower_word_reg} = 32'h00000010;
    for (int k = 0; k < 4; k++) begin
      i_product_shift_select = k[2:0]; i_product = 32'h00000008 << k;
      op(16'hFF59); flg(3'b011);
    end
    {i_upper_word_reg, i_lower_word_reg} = 32'hFFFFFFF0; i_product_shift_select = 3'h2; i_product = 32'hFFFFFFE0;
    op(16'hFF59); flg(3'b011);
    i_prev_repeat_next_instr = 1'b1; i_mem_operand_32 = 32'hFFFFFFF0;
    op(16'h0F00); chk("rpt_clr", o_repeat_count_clr, 1'b1); flg(3'b011);
    i_prev_repeat_next_instr = 1'b0;
    @(posedge i_ref_clk); #1 chk("rpt_once", o_flags_we, 1'b0);
    chk("hold_z", o_zero_flag, 1'b1);
    op(16'h2900); chk("unk_we", o_flags_we, 1'b0);
    end_of_test();
  end
endmodule : cfu_compare_flag_unit_tb
`default_nettype wire
